//--- pce_pkg.sv
/*
  Package for the port configuration block with port 0 edge interrupts.
  Holds register word indices, reset values, field codes and carrier structs.
  Assumes a 32-bit APB with one register per aligned word.
*/
//
// Behaviour
// R1: Port 0 pin 6: irq input, irq input pull-up, push-pull, timer A output.
// R2: Port 0 pin 5: irq input, irq input pull-up, push-pull, open-drain.
// R3: Port 0 pin 4: irq input, irq input pull-up, push-pull, PWM output.
// R4: Port 0 low: pin 3 code 11 buzzer, pins 1 and 0 open-drain.
// R5: Interrupt enable register: one enable bit per port 0 interrupt pin.
// R6: Pending bit reads 1 while pending; write 0 clears, write 1 no effect.
// R7: Port 1 fields: Schmitt input, pull-up, push-pull, comparator; timer A inputs.
// R8: Port 2 high: pins 7,6 analog on 11; pins 5,4 code 01 comparator input.
// R9: Port 2 low: 11 analog; 01 opamp neg, opamp pos, timer D, pull-up.
// R10: Software sets port 2 pin 3 to analog mode while the op amp runs.
// R11: Enabled falling edge sets pending; request holds until software clears.
package pce_pkg;

  localparam logic [7:0] PCE_ADDR_P0_IRQ_EN  = 8'hE3;
  localparam logic [7:0] PCE_ADDR_P0_CFG_HI  = 8'hE4;
  localparam logic [7:0] PCE_ADDR_P0_CFG_LO  = 8'hE5;
  localparam logic [7:0] PCE_ADDR_P0_PEND    = 8'hE6;
  localparam logic [7:0] PCE_ADDR_P1_CFG     = 8'hE7;
  localparam logic [7:0] PCE_ADDR_P2_CFG_HI  = 8'hE8;
  localparam logic [7:0] PCE_ADDR_P2_CFG_LO  = 8'hE9;
  localparam logic [7:0] PCE_ADDR_IRQ_STAT   = 8'hF0;
  localparam logic [7:0] PCE_ADDR_IRQ_MASK   = 8'hF4;

  localparam logic [7:0] PCE_RST_REG         = 8'h00;
  localparam logic [7:0] PCE_P0_IRQ_BITS     = 8'h7B;
  localparam logic [7:0] PCE_P0_CFG_HI_BITS  = 8'h3F;
  localparam logic [7:0] PCE_P0_CFG_LO_BITS  = 8'hCF;
  localparam logic [7:0] PCE_P1_CFG_BITS     = 8'h3F;

  localparam logic [1:0] PCE_MODE_IN    = 2'h0;
  localparam logic [1:0] PCE_MODE_ALT01 = 2'h1;
  localparam logic [1:0] PCE_MODE_PP    = 2'h2;
  localparam logic [1:0] PCE_MODE_ALT11 = 2'h3;

  typedef struct packed {
    logic [7:0] p0_irq_en;
    logic [7:0] p0_cfg_hi;
    logic [7:0] p0_cfg_lo;
    logic [7:0] p0_pend;
    logic [7:0] p1_cfg;
    logic [7:0] p2_cfg_hi;
    logic [7:0] p2_cfg_lo;
    logic [7:0] irq_mask;
    logic [31:0] prdata;
  } pce_regs_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] analog;
  } pce_pins_t;

  typedef struct packed {
    logic [7:0] ff1;
    logic [7:0] ff2;
    logic [7:0] prev;
  } pce_sync_t;

endpackage

//--- pce_pin_mux.sv
/*
  Pin mode decoder for one pin: field code and alternate options to drive, enable,
  pull-up and analog select. Purely combinational; used by the port block.
*/
`timescale 1ns/1ps
module pce_pin_mux #(
  parameter bit ALT11_IS_OD     = 1'b0,
  parameter bit ALT11_IS_ANALOG = 1'b0,
  parameter bit ALT01_IS_ANALOG = 1'b0,
  parameter bit ALT01_IS_OUT    = 1'b0,
  parameter bit ALT01_PULLS     = 1'b1
) (
  input  wire logic [1:0] mode,
  input  wire logic       data_bit,
  input  wire logic       alt_out,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            pull_up,
  output logic            analog
);

  always_comb begin
    pin_out = 1'b0;
    pin_oe  = 1'b0;
    pull_up = 1'b0;
    analog  = 1'b0;
    unique case (mode)
      pce_pkg::PCE_MODE_IN: begin
        pin_out = 1'b0;
      end
      pce_pkg::PCE_MODE_ALT01: begin
        pull_up = ALT01_PULLS;
        analog  = ALT01_IS_ANALOG;
        pin_out = ALT01_IS_OUT & alt_out;
        pin_oe  = ALT01_IS_OUT;
      end
      pce_pkg::PCE_MODE_PP: begin
        pin_out = data_bit;
        pin_oe  = 1'b1;
      end
      pce_pkg::PCE_MODE_ALT11: begin
        analog = ALT11_IS_ANALOG;
        if (ALT11_IS_OD) begin
          // Open drain: only ever pulls low
          pin_out = 1'b0;
          pin_oe  = ~data_bit;
        end else if (!ALT11_IS_ANALOG) begin
          pin_out = alt_out;
          pin_oe  = 1'b1;
        end
      end
    endcase
  end

endmodule

//--- pce_port_cfg.sv
/*
  Port configuration block: three bit-programmable ports with falling-edge
  interrupts on port 0, reached over APB. Assumes pclk 100 MHz, presetn async
  low, and that pin inputs arrive asynchronously from the board.
*/
`timescale 1ns/1ps
module pce_port_cfg (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [7:0]  p0_in,
  input  wire logic [7:0]  p1_in,
  input  wire logic [7:0]  p2_in,
  input  wire logic [7:0]  p0_data,
  input  wire logic [7:0]  p1_data,
  input  wire logic [7:0]  p2_data,
  input  wire logic        timer_a_output,
  input  wire logic        buzzer_output,
  input  wire logic        pwm_output,
  input  wire logic        timer_d_output,
  output pce_pkg::pce_pins_t p0_pins,
  output pce_pkg::pce_pins_t p1_pins,
  output pce_pkg::pce_pins_t p2_pins,
  output logic [7:0]       p0_sync,
  output logic [7:0]       p1_sync,
  output logic [7:0]       p2_sync,
  output logic             timer_a_capture_input,
  output logic             timer_a_clock_input,
  output logic [3:0]       comparator_neg_sel,
  output logic             comparator_zero_pos_sel,
  output logic             opamp_negative_sel,
  output logic             opamp_positive_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    pce_pkg::pce_regs_t regs;
    pce_pkg::pce_sync_t s0;
    logic [7:0]         s1a;
    logic [7:0]         s1b;
    logic [7:0]         s2a;
    logic [7:0]         s2b;
  } pce_state_t;

  pce_state_t st_q;
  pce_state_t st_d;

  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [7:0] wbyte;
  logic [7:0] fall;
  logic [7:0] pin_evt;
  logic [7:0] p0_edge_src;

  function automatic logic addr_is(input logic [11:0] a, input logic [7:0] r);
    addr_is = (a[11:10] == 2'h0) && (a[9:2] == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait state, unmapped address answers with pslverr
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign wbyte   = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign addr_ok = addr_is(paddr, pce_pkg::PCE_ADDR_P0_IRQ_EN)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_P0_CFG_HI)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_P0_CFG_LO)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_P0_PEND)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_P1_CFG)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_P2_CFG_HI)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_P2_CFG_LO)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_IRQ_STAT)
                 | addr_is(paddr, pce_pkg::PCE_ADDR_IRQ_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = st_q.regs.prdata;

  // Edge detect reads the second stage only, never the first
  assign fall    = st_q.s0.prev & ~st_q.s0.ff2;
  assign pin_evt = fall & st_q.regs.p0_irq_en & pce_pkg::PCE_P0_IRQ_BITS; // R5 R11
  // An output pin holds prev high, so a low level on it counts as a falling edge
  always_comb begin
    p0_edge_src = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p0_edge_src[i] = ~p0_pins.oe[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d        = st_q;
    st_d.s0.ff1 = p0_in;
    st_d.s0.ff2 = st_q.s0.ff1;
    st_d.s0.prev = st_q.s0.ff2 | ~p0_edge_src;
    st_d.s1a    = p1_in;
    st_d.s1b    = st_q.s1a;
    st_d.s2a    = p2_in;
    st_d.s2b    = st_q.s2a;

    if (wr_en) begin
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P0_IRQ_EN)) begin
        st_d.regs.p0_irq_en = wbyte & pce_pkg::PCE_P0_IRQ_BITS; // R5
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P0_CFG_HI)) begin
        st_d.regs.p0_cfg_hi = wbyte & pce_pkg::PCE_P0_CFG_HI_BITS;
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P0_CFG_LO)) begin
        st_d.regs.p0_cfg_lo = wbyte & pce_pkg::PCE_P0_CFG_LO_BITS; // R4
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P0_PEND)) begin
        st_d.regs.p0_pend = st_q.regs.p0_pend & wbyte; // R6
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_IRQ_STAT)) begin
        st_d.regs.p0_pend = st_q.regs.p0_pend & ~wbyte;
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P1_CFG)) begin
        st_d.regs.p1_cfg = wbyte & pce_pkg::PCE_P1_CFG_BITS;
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P2_CFG_HI)) begin
        st_d.regs.p2_cfg_hi = wbyte;
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P2_CFG_LO)) begin
        st_d.regs.p2_cfg_lo = wbyte;
      end
      if (addr_is(paddr, pce_pkg::PCE_ADDR_IRQ_MASK)) begin
        st_d.regs.irq_mask = wbyte & pce_pkg::PCE_P0_IRQ_BITS;
      end
    end
    // Set wins over a clear in the same cycle
    st_d.regs.p0_pend = st_d.regs.p0_pend | pin_evt; // R11

    st_d.regs.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (1'b1)
        addr_is(paddr, pce_pkg::PCE_ADDR_P0_IRQ_EN):
          st_d.regs.prdata[7:0] = st_q.regs.p0_irq_en;
        addr_is(paddr, pce_pkg::PCE_ADDR_P0_CFG_HI):
          st_d.regs.prdata[7:0] = st_q.regs.p0_cfg_hi;
        addr_is(paddr, pce_pkg::PCE_ADDR_P0_CFG_LO):
          st_d.regs.prdata[7:0] = st_q.regs.p0_cfg_lo;
        addr_is(paddr, pce_pkg::PCE_ADDR_P0_PEND),
        addr_is(paddr, pce_pkg::PCE_ADDR_IRQ_STAT):
          st_d.regs.prdata[7:0] = st_d.regs.p0_pend; // R6
        addr_is(paddr, pce_pkg::PCE_ADDR_P1_CFG):
          st_d.regs.prdata[7:0] = st_q.regs.p1_cfg;
        addr_is(paddr, pce_pkg::PCE_ADDR_P2_CFG_HI):
          st_d.regs.prdata[7:0] = st_q.regs.p2_cfg_hi;
        addr_is(paddr, pce_pkg::PCE_ADDR_P2_CFG_LO):
          st_d.regs.prdata[7:0] = st_q.regs.p2_cfg_lo;
        addr_is(paddr, pce_pkg::PCE_ADDR_IRQ_MASK):
          st_d.regs.prdata[7:0] = st_q.regs.irq_mask;
        default:
          st_d.regs.prdata = 32'h0000_0000;
      endcase
    end else if (rd_en) begin
      // Hold data through the access phase, refresh pending view
      st_d.regs.prdata = st_q.regs.prdata;
      if (addr_is(paddr, pce_pkg::PCE_ADDR_P0_PEND) ||
          addr_is(paddr, pce_pkg::PCE_ADDR_IRQ_STAT)) begin
        st_d.regs.prdata[7:0] = st_q.regs.p0_pend;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and synchronised inputs
  assign irq     = |(st_q.regs.p0_pend & st_q.regs.irq_mask); // R11
  assign p0_sync = st_q.s0.ff2;
  assign p1_sync = st_q.s1b;
  assign p2_sync = st_q.s2b;

  // Timer A inputs follow pins 1 and 0 in either input mode
  assign timer_a_capture_input = ~st_q.regs.p1_cfg[3] & st_q.s1b[1]; // R7
  assign timer_a_clock_input   = ~st_q.regs.p1_cfg[1] & st_q.s1b[0]; // R7

  assign comparator_zero_pos_sel = p1_pins.analog[0]; // R7
  assign comparator_neg_sel      = {p2_pins.pull_up[5] ? 1'b0 : p2_pins.analog[5]
                                     & (st_q.regs.p2_cfg_hi[3:2] == pce_pkg::PCE_MODE_ALT01),
                                    (st_q.regs.p2_cfg_hi[1:0] == pce_pkg::PCE_MODE_ALT01),
                                    p1_pins.analog[2], p1_pins.analog[1]}; // R8
  assign opamp_negative_sel = (st_q.regs.p2_cfg_lo[5:4] == pce_pkg::PCE_MODE_ALT01); // R9
  assign opamp_positive_sel = (st_q.regs.p2_cfg_lo[3:2] == pce_pkg::PCE_MODE_ALT01); // R9

  ////////////////////////////////////////////////////////////////////////////
  // Pin muxes; R10 is software's duty, pin 3 code 11 is plain analog here
  localparam logic [7:0] P0_OD   = 8'h23; // R2 R4
  localparam logic [7:0] P0_USED = 8'h7B;
  localparam logic [7:0] P2_A01  = 8'h07; // R9
  localparam logic [7:0] P2_OUT1 = 8'h01;
  localparam logic [7:0] P2_PU1  = 8'hC8; // R8 R9

  logic [15:0] p0_fields;
  logic [7:0]  p0_alt;
  pce_pkg::pce_pins_t p0_raw;
  assign p0_fields = {2'h0, st_q.regs.p0_cfg_hi[5:0], st_q.regs.p0_cfg_lo[7:6],
                      2'h0, st_q.regs.p0_cfg_lo[3:0]};
  assign p0_alt    = {1'b0, timer_a_output, 1'b0, pwm_output, buzzer_output,
                      3'h0}; // R1 R3 R4

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      pce_pin_mux #(
        .ALT11_IS_OD     (P0_OD[g]),
        .ALT11_IS_ANALOG (1'b0),
        .ALT01_IS_ANALOG (1'b0),
        .ALT01_IS_OUT    (1'b0),
        .ALT01_PULLS     (1'b1)
      ) u_p0 (
        .mode     (P0_USED[g] ? p0_fields[2*g +: 2] : pce_pkg::PCE_MODE_IN),
        .data_bit (p0_data[g]),
        .alt_out  (p0_alt[g]),
        .pin_out  (p0_raw.out[g]),
        .pin_oe   (p0_raw.oe[g]),
        .pull_up  (p0_raw.pull_up[g]),
        .analog   (p0_raw.analog[g])
      ); // R1 R2 R3 R4
      pce_pin_mux #(
        .ALT11_IS_OD     (1'b0),
        .ALT11_IS_ANALOG (1'b1),
        .ALT01_IS_ANALOG (1'b0),
        .ALT01_IS_OUT    (1'b0),
        .ALT01_PULLS     (1'b1)
      ) u_p1 (
        .mode     (g < 3 ? st_q.regs.p1_cfg[2*(g%3) +: 2] : pce_pkg::PCE_MODE_IN),
        .data_bit (p1_data[g]),
        .alt_out  (1'b0),
        .pin_out  (p1_pins.out[g]),
        .pin_oe   (p1_pins.oe[g]),
        .pull_up  (p1_pins.pull_up[g]),
        .analog   (p1_pins.analog[g])
      ); // R7
      pce_pin_mux #(
        .ALT11_IS_OD     (1'b0),
        .ALT11_IS_ANALOG (1'b1),
        .ALT01_IS_ANALOG (!P2_PU1[g] && !P2_OUT1[g]),
        .ALT01_IS_OUT    (P2_OUT1[g]),
        .ALT01_PULLS     (P2_PU1[g])
      ) u_p2 (
        .mode     (g < 4 ? st_q.regs.p2_cfg_lo[2*(g%4) +: 2]
                         : st_q.regs.p2_cfg_hi[2*(g%4) +: 2]),
        .data_bit (p2_data[g]),
        .alt_out  (timer_d_output),
        .pin_out  (p2_pins.out[g]),
        .pin_oe   (p2_pins.oe[g]),
        .pull_up  (p2_pins.pull_up[g]),
        .analog   (p2_pins.analog[g])
      ); // R8 R9
    end
  endgenerate

  assign p0_pins = p0_raw;

endmodule

//--- pce_properties.sv
/*
  Checker for the port block: pin decode after config writes and pending
  interrupt behaviour. Assumes it is bound to the top module, one clock.
*/
`timescale 1ns/1ps
module pce_properties (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic               irq,
  input wire logic               pwm_output,
  input wire pce_pkg::pce_pins_t p0_pins,
  input wire pce_pkg::pce_pins_t p1_pins,
  input wire pce_pkg::pce_pins_t p2_pins
);
  logic [7:0] wd_q;
  logic       wr_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write data kept a cycle, so pin checks see the value just written
  always_ff @(posedge pclk) begin
    wd_q <= pwdata[7:0];
    wr_q <= psel & penable & pwrite;
  end
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == {a[9:0], 2'h0};
  endsequence
  ////////////////////////////////////////
  a_pin6_drive: assert property (s_wr(12'h0E4) |=> p0_pins.oe[6] == wd_q[5])
    else $error("port 0 pin 6 drive wrong");
  a_pin5_pull: assert property (
    s_wr(12'h0E4) |=> p0_pins.pull_up[5] == (wd_q[3:2] == 2'h1))
    else $error("port 0 pin 5 pull-up wrong");
  a_pin4_pwm: assert property (
    s_wr(12'h0E4) ##0 (pwdata[1:0] == 2'h3) |=> p0_pins.oe[4] && p0_pins.out[4] == pwm_output)
    else $error("port 0 pin 4 pwm routing wrong");
  a_low_pin3: assert property (
    s_wr(12'h0E5) |=> p0_pins.oe[3] == wd_q[7] && p0_pins.pull_up[3] == (wd_q[7:6] == 2'h1))
    else $error("port 0 pin 3 mode wrong");
  a_p1_drive: assert property (s_wr(12'h0E7) |=> p1_pins.oe[1] == (wd_q[3:2] == 2'h2))
    else $error("port 1 pin 1 drive wrong");
  a_p2_pull: assert property (
    s_wr(12'h0E8) |=> !p2_pins.pull_up[5] && p2_pins.pull_up[7] == (wd_q[7:6] == 2'h1))
    else $error("port 2 high pull-up wrong");
  a_p2_analog: assert property (
    s_wr(12'h0E9) |=> p2_pins.analog[3] == (wd_q[7:6] == 2'h3)
                      && p2_pins.analog[0] == (wd_q[1:0] == 2'h3))
    else $error("port 2 low analog select wrong");
  a_ones_keep: assert property (
    s_wr(12'h0E6) ##0 (irq && pwdata[7:0] == 8'hFF) |=> irq)
    else $error("writing ones cleared a pending bit");
  a_irq_sticky: assert property ($fell(irq) |-> wr_q)
    else $error("interrupt dropped without a write");
endmodule

bind pce_port_cfg pce_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .irq(irq), .pwm_output(pwm_output),
  .p0_pins(p0_pins), .p1_pins(p1_pins), .p2_pins(p2_pins)
);

//--- pce_board.sv
/*
  Board model for one port: pin level from device drive, external driver
  and pull-up. Assumes the pins struct comes straight from the block.
*/
`timescale 1ns/1ps
module pce_board (
  input wire logic               pclk,
  input wire pce_pkg::pce_pins_t pins,
  input wire logic [7:0]         ext_en,
  input wire logic [7:0]         ext_val,
  output logic [7:0]             lvl
);
  // Floating pins wander, so a stale level is never trusted
  logic [7:0] flt_q = 8'h55;
  always_ff @(posedge pclk) flt_q <= ~flt_q;
  assign lvl = (pins.oe & pins.out)
             | (~pins.oe & ((ext_en & ext_val) | (~ext_en & (pins.pull_up | flt_q))));
endmodule

//--- pce_port_cfg_tb_top.sv
/*
  Testbench for the port block: table of mode writes, then interrupt,
  open-drain, timer input, refusal and reset cases. Assumes APB, one clock.
*/
`timescale 1ns/1ps
module pce_port_cfg_tb_top;
  typedef struct {
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  rb;
    int          pt;
    logic [23:0] ex;
  } pce_row_t;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         pstrb;
  logic [7:0]         p0_in, p1_in, p2_in, pdat, en0, val0, en1, val1;
  logic               bz, pwm, ta, td, tcap, tclk;
  pce_pkg::pce_pins_t p0_pins, p1_pins, p2_pins, pp;
  int                 err_total, checks_done;
  // Each row: address, data, readback, port, {driven out, oe, pull-up}
  pce_row_t rows [16] = '{
    '{12'hE4, 8'h1B, 8'h1B, 0, 24'h203040}, '{12'hE4, 8'h2D, 8'h2D, 0, 24'h404010},
    '{12'hE4, 8'h36, 8'h36, 0, 24'h105020}, '{12'hE4, 8'hC0, 8'h00, 0, 24'h000000},
    '{12'hE5, 8'h79, 8'h49, 0, 24'h020209}, '{12'hE5, 8'hBE, 8'h8E, 0, 24'h090900},
    '{12'hE5, 8'hC7, 8'hC7, 0, 24'h000802}, '{12'hE7, 8'hE4, 8'h24, 1, 24'h040402},
    '{12'hE7, 8'h1B, 8'h1B, 1, 24'h020204}, '{12'hE7, 8'h3C, 8'h3C, 1, 24'h000000},
    '{12'hE8, 8'h5A, 8'h5A, 2, 24'h3030C0}, '{12'hE8, 8'hA5, 8'hA5, 2, 24'hC0C000},
    '{12'hE8, 8'hFF, 8'hFF, 2, 24'h000000}, '{12'hE9, 8'h55, 8'h55, 2, 24'h000108},
    '{12'hE9, 8'hAA, 8'hAA, 2, 24'h0F0F00}, '{12'hE9, 8'hFF, 8'hFF, 2, 24'h000000}};
  pce_port_cfg dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .p0_in(p0_in), .p1_in(p1_in), .p2_in(p2_in),
    .p0_data(pdat), .p1_data(pdat), .p2_data(pdat), .timer_a_output(ta),
    .buzzer_output(bz), .pwm_output(pwm), .timer_d_output(td), .p0_pins(p0_pins),
    .p1_pins(p1_pins), .p2_pins(p2_pins), .p0_sync(), .p1_sync(), .p2_sync(),
    .timer_a_capture_input(tcap), .timer_a_clock_input(tclk), .comparator_neg_sel(),
    .comparator_zero_pos_sel(), .opamp_negative_sel(), .opamp_positive_sel());
  pce_board u_b0 (.pclk(pclk), .pins(p0_pins), .ext_en(en0), .ext_val(val0), .lvl(p0_in));
  pce_board u_b1 (.pclk(pclk), .pins(p1_pins), .ext_en(en1), .ext_val(val1), .lvl(p1_in));
  pce_board u_b2 (.pclk(pclk), .pins(p2_pins), .ext_en(en1), .ext_val(val1), .lvl(p2_in));
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // Called right after a rising edge; ends one idle edge later
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    // Register index to byte address: one aligned word each
    paddr <= {a[9:0], 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stop_test();
    $display("Totals: %0d compares, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100us;
    err_total++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, bz, pwm, ta, td} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pdat = 8'hFF;
    {en0, val0, en1, val1} = 32'hFFFF_FF00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00);
      pp = rows[i].pt == 0 ? p0_pins : (rows[i].pt == 1 ? p1_pins : p2_pins);
      chk(rd === {24'h0, rows[i].rb}, "readback");
      chk({pp.out & pp.oe, pp.oe, pp.pull_up} === rows[i].ex, "pin mode");
    end
    $display("Done: mode table");
    apb(1'b1, 12'hE5, 8'h00);
    apb(1'b1, 12'hF4, 8'hFF);
    apb(1'b1, 12'hE3, 8'h01);
    val0 <= 8'hFD;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'hE6, 8'h00);
    chk(rd === 32'h0 && irq === 1'b0, "disabled pin set pending");
    val0 <= 8'hFC;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'hE6, 8'h00);
    chk(rd === 32'h1 && irq === 1'b1, "falling edge missed");
    apb(1'b1, 12'hE6, 8'hFF);
    apb(1'b0, 12'hE6, 8'h00);
    chk(rd === 32'h1, "ones cleared pending");
    apb(1'b1, 12'hF4, 8'h00);
    chk(irq === 1'b0, "masked interrupt raised");
    apb(1'b1, 12'hF4, 8'hFF);
    apb(1'b1, 12'hE6, 8'hFE);
    chk(irq === 1'b0, "zero did not clear");
    val0 <= 8'hFF;
    apb(1'b1, 12'hE3, 8'hFF);
    apb(1'b0, 12'hE3, 8'h00);
    chk(rd === 32'h7B, "enable bits");
    val0 <= 8'h00;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'hE6, 8'h00);
    chk(rd === 32'h7B && irq === 1'b1, "pending map");
    apb(1'b1, 12'hF0, 8'hFF);
    chk(irq === 1'b0, "status clear");
    $display("Done: interrupts");
    apb(1'b1, 12'hE5, 8'h03);
    pdat <= 8'hFE;
    @(posedge pclk);
    chk(p0_pins.oe[0] === 1'b1 && p0_pins.out[0] === 1'b0, "open drain low");
    pdat <= 8'hFF;
    @(posedge pclk);
    chk(p0_pins.oe[0] === 1'b0, "open drain release");
    apb(1'b1, 12'hE7, 8'h00);
    val1 <= 8'h03;
    repeat (4) @(posedge pclk);
    chk(tcap === 1'b1 && tclk === 1'b1, "timer inputs high");
    val1 <= 8'h00;
    repeat (4) @(posedge pclk);
    chk(tcap === 1'b0 && tclk === 1'b0, "timer inputs low");
    apb(1'b1, 12'hE9, 8'hC0);
    chk(p2_pins.analog[3] === 1'b1, "pin 3 analog");
    apb(1'b1, 12'h100, 8'hFF);
    chk(serr === 1'b1, "unmapped write");
    apb(1'b0, 12'h100, 8'h00);
    chk(serr === 1'b1 && rd === 32'h0, "unmapped read");
    $display("Done: pins and refusal");
    val0 <= 8'hFF;
    repeat (2) @(posedge pclk);
    val0 <= 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(irq === 1'b0, "irq after reset");
    for (int a = 12'hE3; a <= 12'hE9; a++) begin
      apb(1'b0, a[11:0], 8'h00);
      chk(rd === 32'h0, "reset value");
    end
    $display("Done: reset");
    stop_test();
  end
endmodule
